// >>> axa_pkg.sv
// Purpose: shared constants for the aux i/o, low-bit and averager block
// Assumes: plain register port, byte offsets, 32-bit data
// Notes:   all widths fixed

package axa_pkg;

    // ============
    // register offsets
    localparam logic [7:0] AXA_REG_AUX_MODE  = 8'h00;
    localparam logic [7:0] AXA_REG_AUX_PARAM = 8'h04;
    localparam logic [7:0] AXA_REG_LOWBIT    = 8'h08;
    localparam logic [7:0] AXA_REG_AVG_CTRL  = 8'h0C;
    localparam logic [7:0] AXA_REG_REC_LEN   = 8'h10;
    localparam logic [7:0] AXA_REG_AVG_CNT   = 8'h14;
    localparam logic [7:0] AXA_REG_STATUS    = 8'h18;
    localparam logic [7:0] AXA_REG_CMD       = 8'h1C;
    localparam logic [7:0] AXA_REG_BUF_RECS  = 8'h20;

    // ============
    // field positions
    localparam int AXA_SWTE_BIT    = 4;
    localparam int AXA_SLOPE_BIT   = 0;
    localparam int AXA_LEVEL_BIT   = 0;
    localparam int AXA_LB1_LSB     = 4;
    localparam int AXA_AVG_ON_BIT  = 0;
    localparam int AXA_SIGNED_BIT  = 1;
    localparam int AXA_FORCE_BIT   = 0;

    // ============
    // aux modes and low-bit sources
    localparam logic [3:0] AXA_AUX_BUSY_OUT   = 4'h0;
    localparam logic [3:0] AXA_AUX_TE_IN      = 4'h1;
    localparam logic [3:0] aux_clock_divider_mode = 4'h2;
    localparam logic [3:0] aux_level_input_mode   = 4'hD;
    localparam logic [3:0] AXA_AUX_STATIC_OUT = 4'hE;

    localparam logic [1:0] AXA_LB_ZERO = 2'h0;
    localparam logic [1:0] lowbit_ext_trigger_select = 2'h1;
    localparam logic [1:0] AXA_LB_AUX2 = 2'h2;
    localparam logic [1:0] AXA_LB_AUX1 = 2'h3;

    // ============
    // widths and reset values
    localparam int AXA_SMP_W   = 16;
    localparam int AXA_ACC_W   = 32;
    localparam int AXA_CNT_W   = 24;
    localparam int AXA_LEN_W   = 11;
    localparam int AXA_IDX_W   = 10;
    localparam int AXA_DEPTH   = 1024;
    localparam logic [AXA_LEN_W-1:0] AXA_LEN_RST  = 11'h010;
    localparam logic [AXA_CNT_W-1:0] AXA_CNT_RST  = 24'h000001;
    localparam logic [15:0]          AXA_PAR_RST  = 16'h0004;
    localparam logic [15:0]          AXA_BUFR_RST = 16'h0001;

endpackage : axa_pkg

// >>> axa_lowbit_sel.sv
// Purpose: picks the signal placed in one unused low sample bit
// Assumes: inputs already synchronous to clk_sys
// Notes:   one instance per low bit

`timescale 1ns/1ns

module axa_lowbit_sel (
    // selection
    input  wire logic [1:0] sel,
    // candidate levels
    input  wire logic       ext_trig_lvl,
    input  wire logic       aux1_lvl,
    input  wire logic       aux2_lvl,
    // chosen bit
    output logic            bit_o
);
    import axa_pkg::*;

    always_comb begin
        unique case (sel)
            AXA_LB_ZERO:               bit_o = 1'b0;
            lowbit_ext_trigger_select: bit_o = ext_trig_lvl;
            AXA_LB_AUX2:               bit_o = aux2_lvl;
            AXA_LB_AUX1:               bit_o = aux1_lvl;
        endcase
    end

endmodule : axa_lowbit_sel

// >>> axa_averager.sv
// Purpose: co-adds records into 32-bit sums and sends them as bytes
// Assumes: host sink never stalls; one byte per clock on drain
// Notes:   triggers are ignored while draining

`timescale 1ns/1ns

module axa_averager (
    // clock and reset
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    // configuration
    input  wire logic                          avg_on,
    input  wire logic                          signed_mode,
    input  wire logic [axa_pkg::AXA_LEN_W-1:0] rec_len,
    input  wire logic [axa_pkg::AXA_CNT_W-1:0] avg_count,
    // samples
    input  wire logic                          rec_start,
    input  wire logic                          smp_valid,
    input  wire logic [axa_pkg::AXA_SMP_W-1:0] smp_a,
    input  wire logic [axa_pkg::AXA_SMP_W-1:0] smp_b,
    // byte stream to host
    output logic                               out_valid_ff,
    output logic [7:0]                         out_byte_ff,
    output logic                               out_last_ff,
    output logic                               draining_ff
);
    import axa_pkg::*;

    typedef enum logic [1:0] {AXA_AV_IDLE, AXA_AV_CAPT, AXA_AV_DRAIN} axa_av_e;

    axa_av_e               st_ff;
    logic [AXA_ACC_W-1:0]  acc_a [AXA_DEPTH];
    logic [AXA_ACC_W-1:0]  acc_b [AXA_DEPTH];
    logic [AXA_IDX_W-1:0]  idx_ff;
    logic [AXA_CNT_W-1:0]  rec_ff;
    logic [2:0]            byte_ff;
    logic [AXA_ACC_W-1:0]  ext_a;
    logic [AXA_ACC_W-1:0]  ext_b;
    logic [AXA_ACC_W-1:0]  word;
    logic                  last_smp;

    assign ext_a = signed_mode ? {{16{smp_a[15]}}, smp_a} : {16'h0000, smp_a};
    assign ext_b = signed_mode ? {{16{smp_b[15]}}, smp_b} : {16'h0000, smp_b};
    assign last_smp = ({1'b0, idx_ff} == rec_len - 11'h001);
    // a then b, each least significant byte first
    assign word = byte_ff[2] ? acc_b[idx_ff] : acc_a[idx_ff];

    // ============
    // accumulator memory
    always_ff @(posedge clk_sys) begin
        if (st_ff == AXA_AV_CAPT && smp_valid) begin
            // first record overwrites, later ones add
            acc_a[idx_ff] <= (rec_ff == 24'h000000) ? ext_a
                                                    : acc_a[idx_ff] + ext_a;
            acc_b[idx_ff] <= (rec_ff == 24'h000000) ? ext_b
                                                    : acc_b[idx_ff] + ext_b;
        end
    end

    // ============
    // sequencing
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_ff   <= AXA_AV_IDLE;
            idx_ff  <= '0;
            rec_ff  <= '0;
            byte_ff <= 3'h0;
        end else begin
            unique case (st_ff)
                AXA_AV_IDLE: begin
                    idx_ff <= '0;
                    if (!avg_on) begin
                        rec_ff <= '0;
                    end else if (rec_start) begin
                        st_ff <= AXA_AV_CAPT;
                    end
                end
                AXA_AV_CAPT: begin
                    if (smp_valid) begin
                        idx_ff <= idx_ff + 10'h001;
                        if (last_smp) begin
                            idx_ff <= '0;
                            // count is its own, not the buffer's
                            if (rec_ff + 24'h000001 >= avg_count) begin
                                st_ff   <= AXA_AV_DRAIN;
                                byte_ff <= 3'h0;
                            end else begin
                                rec_ff <= rec_ff + 24'h000001;
                                st_ff  <= AXA_AV_IDLE;
                            end
                        end
                    end
                end
                AXA_AV_DRAIN: begin
                    byte_ff <= byte_ff + 3'h1;
                    if (byte_ff == 3'h7) begin
                        idx_ff <= idx_ff + 10'h001;
                        if (last_smp) begin
                            st_ff  <= AXA_AV_IDLE; // restart
                            rec_ff <= '0;
                        end
                    end
                end
                default: st_ff <= AXA_AV_IDLE;
            endcase
        end
    end

    // ============
    // byte output
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            out_valid_ff <= 1'b0;
            out_byte_ff  <= 8'h00;
            out_last_ff  <= 1'b0;
            draining_ff  <= 1'b0;
        end else begin
            out_valid_ff <= (st_ff == AXA_AV_DRAIN);
            out_byte_ff  <= word[{byte_ff[1:0], 3'b000} +: 8];
            out_last_ff  <= (st_ff == AXA_AV_DRAIN) && last_smp
                            && (byte_ff == 3'h7);
            // raised with the change of state, so no trigger slips in
            draining_ff  <= (st_ff == AXA_AV_DRAIN
                             && !(last_smp && byte_ff == 3'h7))
                            || (st_ff == AXA_AV_CAPT && smp_valid && last_smp
                                && rec_ff + 24'h000001 >= avg_count);
        end
    end

endmodule : axa_averager

// >>> axa_top.sv
// Purpose: aux pin modes, low-bit insertion, busy flag and averager
// Assumes: all inputs synchronous to clk_sys; host sink never stalls
// Notes:   registers on a plain strobe port, read data one cycle later
//
// What this block does
// - busy reads 1 while capturing, else 0
// - mode 0 drives pin with capture busy
// - mode 1 pin edge gives trigger-enable event
// - mode 2 outputs clock divided, divisor 2 or above
// - mode 14 drives static level from parameter
// - mode 13 pin level readable in status
// - software enable: force, fill buffer, rearm
// - samples msb aligned, low bits zero default
// - each low bit picks its own source
// - averaging co-adds records, sends sums instead
// - one sum record per count, then restart
// - 32-bit sums, least significant byte first
// - sum records hold both channels interleaved
// - record count accepts up to 24 bits
// - average count independent of buffer records
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.

`timescale 1ns/1ns

module axa_top (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata_ff,
    // aux pin 1 (three signals) and other levels
    input  wire logic        aux_i,
    output logic             aux_o_ff,
    output logic             aux_oe_ff,
    input  wire logic        aux2_i,
    input  wire logic        ext_trig_i,
    // trigger in and events out
    input  wire logic        trig_i,
    output logic             trig_accept_ff,
    output logic             te_event_ff,
    output logic             busy_ff,
    // converter samples, msb aligned
    input  wire logic        smp_valid,
    input  wire logic [15:0] smp_a,
    input  wire logic [15:0] smp_b,
    // raw sample output
    output logic             raw_valid_ff,
    output logic [15:0]      raw_a_ff,
    output logic [15:0]      raw_b_ff,
    // accumulator byte stream
    output logic             avg_valid_ff,
    output logic [7:0]       avg_byte_ff,
    output logic             avg_last_ff
);
    import axa_pkg::*;

    // ============
    // configuration registers
    logic [3:0]            aux_mode_ff;
    logic                  swte_ff;
    logic [15:0]           aux_param_ff;
    logic [1:0]            lowbit0_source;
    logic [1:0]            lowbit1_source;
    logic                  averager_on;
    logic                  signed_ff;
    logic [AXA_LEN_W-1:0]  accumulator_record_length;
    logic [AXA_CNT_W-1:0]  average_record_count;
    logic [15:0]           buf_recs_ff;
    logic                  force_te;

    assign force_te = reg_wr && (reg_addr == AXA_REG_CMD)
                      && reg_wdata[AXA_FORCE_BIT];

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aux_mode_ff               <= AXA_AUX_BUSY_OUT;
            swte_ff                   <= 1'b0;
            aux_param_ff              <= AXA_PAR_RST;
            lowbit0_source            <= AXA_LB_ZERO;
            lowbit1_source            <= AXA_LB_ZERO;
            averager_on               <= 1'b0;
            signed_ff                 <= 1'b0;
            accumulator_record_length <= AXA_LEN_RST;
            average_record_count      <= AXA_CNT_RST;
            buf_recs_ff               <= AXA_BUFR_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                AXA_REG_AUX_MODE: begin
                    aux_mode_ff <= reg_wdata[3:0];
                    swte_ff     <= reg_wdata[AXA_SWTE_BIT];
                end
                AXA_REG_AUX_PARAM: aux_param_ff <= reg_wdata[15:0];
                AXA_REG_LOWBIT: begin
                    lowbit0_source <= reg_wdata[1:0];
                    lowbit1_source <= reg_wdata[AXA_LB1_LSB +: 2];
                end
                AXA_REG_AVG_CTRL: begin
                    averager_on <= reg_wdata[AXA_AVG_ON_BIT];
                    signed_ff   <= reg_wdata[AXA_SIGNED_BIT];
                end
                AXA_REG_REC_LEN:
                    accumulator_record_length <= reg_wdata[AXA_LEN_W-1:0];
                AXA_REG_AVG_CNT:
                    average_record_count <= reg_wdata[AXA_CNT_W-1:0];
                AXA_REG_BUF_RECS: buf_recs_ff <= reg_wdata[15:0];
                default: ;
            endcase
        end
    end

    // ============
    // aux pin input side
    logic aux_lvl_ff;
    logic aux_prev_ff;
    logic pin_edge;
    logic out_mode;
    logic gated;
    logic te_now;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aux_lvl_ff  <= 1'b0;
            aux_prev_ff <= 1'b0;
        end else begin
            aux_lvl_ff  <= aux_i;
            aux_prev_ff <= aux_lvl_ff;
        end
    end

    // slope 0 rising, 1 falling
    assign pin_edge = aux_param_ff[AXA_SLOPE_BIT]
                      ? (aux_prev_ff && !aux_lvl_ff)
                      : (!aux_prev_ff && aux_lvl_ff);
    assign out_mode = (aux_mode_ff == AXA_AUX_BUSY_OUT)
                      || (aux_mode_ff == aux_clock_divider_mode)
                      || (aux_mode_ff == AXA_AUX_STATIC_OUT);
    assign gated    = (aux_mode_ff == AXA_AUX_TE_IN)
                      || (swte_ff && out_mode);
    assign te_now   = ((aux_mode_ff == AXA_AUX_TE_IN) && pin_edge)
                      || (swte_ff && out_mode && force_te);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            te_event_ff <= 1'b0;
        end else begin
            te_event_ff <= te_now;
        end
    end

    // ============
    // trigger gate: opened by an enable event, closed after a buffer
    logic        gate_open_ff;
    logic [15:0] gate_cnt_ff;
    logic        draining;
    logic        accept;

    assign accept = trig_i && !busy_ff && !draining
                    && (!gated || gate_open_ff);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            gate_open_ff <= 1'b0;
            gate_cnt_ff  <= 16'h0000;
        end else if (te_now) begin
            gate_open_ff <= 1'b1;
            gate_cnt_ff  <= 16'h0000;
        end else if (accept && gated) begin
            gate_cnt_ff <= gate_cnt_ff + 16'h0001;
            // buffer full: wait for the next enable event
            if (gate_cnt_ff + 16'h0001 >= buf_recs_ff) begin
                gate_open_ff <= 1'b0;
            end
        end
    end

    // ============
    // capture busy over one record
    logic [AXA_LEN_W-1:0] cap_cnt_ff;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            busy_ff        <= 1'b0;
            cap_cnt_ff     <= '0;
            trig_accept_ff <= 1'b0;
        end else begin
            trig_accept_ff <= accept;
            if (accept) begin
                busy_ff    <= 1'b1;
                cap_cnt_ff <= '0;
            end else if (busy_ff && smp_valid) begin
                cap_cnt_ff <= cap_cnt_ff + 11'h001;
                if (cap_cnt_ff + 11'h001 >= accumulator_record_length) begin
                    busy_ff <= 1'b0;
                end
            end
        end
    end

    // ============
    // aux pin output side
    logic [15:0] div_cnt_ff;

    // divisor below 2 is not supported by the pacer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            div_cnt_ff <= 16'h0000;
        end else if (aux_mode_ff != aux_clock_divider_mode
                     || div_cnt_ff + 16'h0001 >= aux_param_ff) begin
            div_cnt_ff <= 16'h0000;
        end else begin
            div_cnt_ff <= div_cnt_ff + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            aux_o_ff  <= 1'b0;
            aux_oe_ff <= 1'b0;
        end else begin
            unique case (aux_mode_ff)
                AXA_AUX_BUSY_OUT: begin
                    aux_o_ff  <= busy_ff;
                    aux_oe_ff <= 1'b1;
                end
                aux_clock_divider_mode: begin
                    aux_o_ff  <= (div_cnt_ff
                                  < {1'b0, aux_param_ff[15:1]});
                    aux_oe_ff <= 1'b1;
                end
                AXA_AUX_STATIC_OUT: begin
                    aux_o_ff  <= aux_param_ff[AXA_LEVEL_BIT];
                    aux_oe_ff <= 1'b1;
                end
                default: begin
                    // input modes and unknown codes leave the pin alone
                    aux_o_ff  <= 1'b0;
                    aux_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // ============
    // low-bit insertion
    logic lb0;
    logic lb1;
    logic [15:0] fmt_a;
    logic [15:0] fmt_b;

    axa_lowbit_sel u_lb0 (
        .sel          (lowbit0_source),
        .ext_trig_lvl (ext_trig_i),
        .aux1_lvl     (aux_lvl_ff),
        .aux2_lvl     (aux2_i),
        .bit_o        (lb0)
    );

    axa_lowbit_sel u_lb1 (
        .sel          (lowbit1_source),
        .ext_trig_lvl (ext_trig_i),
        .aux1_lvl     (aux_lvl_ff),
        .aux2_lvl     (aux2_i),
        .bit_o        (lb1)
    );

    assign fmt_a = {smp_a[15:2], lb1, lb0};
    assign fmt_b = {smp_b[15:2], lb1, lb0};

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            raw_valid_ff <= 1'b0;
            raw_a_ff     <= 16'h0000;
            raw_b_ff     <= 16'h0000;
        end else begin
            // raw path only when averaging is off
            raw_valid_ff <= smp_valid && busy_ff && !averager_on;
            raw_a_ff     <= fmt_a;
            raw_b_ff     <= fmt_b;
        end
    end

    // ============
    // record averager
    axa_averager u_avg (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .avg_on       (averager_on),
        .signed_mode  (signed_ff),
        .rec_len      (accumulator_record_length),
        .avg_count    (average_record_count),
        .rec_start    (accept),
        .smp_valid    (smp_valid),
        .smp_a        (fmt_a),
        .smp_b        (fmt_b),
        .out_valid_ff (avg_valid_ff),
        .out_byte_ff  (avg_byte_ff),
        .out_last_ff  (avg_last_ff),
        .draining_ff  (draining)
    );

    // ============
    // register read, one cycle later
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reg_rdata_ff <= 32'h0000_0000;
        end else if (reg_rd) begin
            unique case (reg_addr)
                AXA_REG_AUX_MODE:
                    reg_rdata_ff <= {27'h0, swte_ff, aux_mode_ff};
                AXA_REG_AUX_PARAM: reg_rdata_ff <= {16'h0000, aux_param_ff};
                AXA_REG_LOWBIT:
                    reg_rdata_ff <= {26'h0, lowbit1_source, 2'b00,
                                     lowbit0_source};
                AXA_REG_AVG_CTRL:
                    reg_rdata_ff <= {30'h0, signed_ff, averager_on};
                AXA_REG_REC_LEN:
                    reg_rdata_ff <= {21'h0, accumulator_record_length};
                AXA_REG_AVG_CNT:
                    reg_rdata_ff <= {8'h00, average_record_count};
                AXA_REG_STATUS:
                    // aux_pin_level_query sits in bit 1
                    reg_rdata_ff <= {28'h0, draining, gate_open_ff,
                                     aux_lvl_ff, busy_ff};
                AXA_REG_BUF_RECS: reg_rdata_ff <= {16'h0000, buf_recs_ff};
                default: reg_rdata_ff <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_ff <= 32'h0000_0000;
        end
    end

endmodule : axa_top

// >>> axa_host_sink.sv
// Purpose: host memory taking the accumulator byte stream
// Assumes: one byte per clock, sink never stalls
// Notes:   bytes packed lsb first, at most eight words kept
`timescale 1ns/1ns
module axa_host_sink (
    // stream in
    input  wire logic       clk_sys,
    input  wire logic       avg_valid_ff,
    input  wire logic [7:0] avg_byte_ff,
    input  wire logic       avg_last_ff,
    // collected record
    output logic [31:0]     words [0:7],
    output int              nbytes,
    output int              last_n
);
    // ============
    // capture
    initial begin
        nbytes = 0;
        last_n = 0;
    end
    always @(posedge clk_sys) begin
        if (avg_valid_ff && nbytes < 32) begin
            words[nbytes/4][8*(nbytes%4)+:8] <= avg_byte_ff;
            nbytes <= nbytes + 1;
        end
        if (avg_last_ff) begin
            last_n <= nbytes + 1;
        end
    end
endmodule : axa_host_sink

// >>> axa_top_sva.sv
// Purpose: port checks for busy, triggers, raw and summed output
// Assumes: one clock domain
// Notes:   mode-dependent pin levels are left to the bench
`timescale 1ns/1ns
module axa_top_sva (
    // clock, reset and causes
    input wire logic        clk_sys,
    input wire logic        rst,
    input wire logic        reg_rd,
    input wire logic        trig_i,
    input wire logic        smp_valid,
    // outputs watched
    input wire logic [31:0] reg_rdata_ff,
    input wire logic        trig_accept_ff,
    input wire logic        busy_ff,
    input wire logic        raw_valid_ff,
    input wire logic        avg_valid_ff,
    input wire logic        avg_last_ff
);
    // ============
    // assertions
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    accept_busy_a: assert property (trig_accept_ff |-> busy_ff)
        else $error("accept without busy");
    accept_cause_a: assert property (trig_accept_ff |-> $past(trig_i))
        else $error("accept without trigger");
    busy_start_a: assert property ($rose(busy_ff) |-> trig_accept_ff)
        else $error("busy rose without accept");
    busy_end_a: assert property ($fell(busy_ff) |->
        $past(smp_valid) || $past(smp_valid, 2))
        else $error("busy fell without sample");
    rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_ff == 32'h0)
        else $error("read data outside read cycle");
    raw_src_a: assert property (raw_valid_ff |-> $past(smp_valid))
        else $error("raw word without sample");
    avg_quiet_a: assert property (avg_valid_ff |->
        !raw_valid_ff && !busy_ff)
        else $error("sum byte during capture");
    last_valid_a: assert property (avg_last_ff |-> avg_valid_ff)
        else $error("last flag without byte");
    stream_run_a: assert property (avg_valid_ff && !avg_last_ff |=>
        avg_valid_ff)
        else $error("sum record has a gap");
endmodule : axa_top_sva
bind axa_top axa_top_sva u_sva (.*);

// >>> tb_top.sv
// Purpose: bench for aux pin modes, low bits, busy and averager
// Assumes: record length 2 throughout
// Notes:   sink model collects the summed bytes
`timescale 1ns/1ns
module tb_top;
    import axa_pkg::*;
    logic        clk_sys, rst, reg_wr, reg_rd, aux_i, aux2_i, m0;
    logic        ext_trig_i, trig_i, smp_valid, aux_o_ff, aux_oe_ff;
    logic        busy_ff, te_event_ff, trig_accept_ff, avg_valid_ff;
    logic        avg_last_ff;
    logic [7:0]  reg_addr, avg_byte_ff;
    logic [15:0] smp_a, smp_b, raw_a_ff, raw_b_ff, raw_exp;
    logic        raw_valid_ff;
    logic [31:0] reg_wdata, reg_rdata_ff, words [0:7];
    int          err_total, num_checks, n_acc, n_te, nbytes, last_n, hi;
    axa_top dut (.*);
    axa_host_sink host (.*);
    // ============
    // clock, event counters, watchdog
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        n_acc <= n_acc + int'(trig_accept_ff);
        n_te  <= n_te + int'(te_event_ff);
    end
    initial begin
        #1_000_000; // about fifty times the expected run
        err_total++;
        wrap_up();
    end
    // ============
    // tasks
    task automatic chk(input string n, input logic [31:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", n, e, s);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] m, e);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk("rdata", reg_rdata_ff & m, e);
        @(posedge clk_sys);
    endtask : rd
    task automatic pin(input logic [1:0] e);
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        chk("pin", {30'h0, aux_oe_ff, aux_o_ff}, {30'h0, e});
        @(posedge clk_sys);
    endtask : pin
    task automatic cap(input logic [15:0] a, b);
        trig_i <= 1'b1;
        @(posedge clk_sys);
        trig_i    <= 1'b0;
        smp_valid <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            smp_a <= a + 16'(4 * i);
            smp_b <= b - 16'(4 * i);
            @(negedge clk_sys);
            if (m0 && i == 1) begin
                chk("busy", {31'h0, busy_ff}, 32'h1);
                chk("aux_o", {31'h0, aux_o_ff}, 32'h1);
                chk("raw_a", {16'h0, raw_a_ff}, {16'h0, raw_exp});
                chk("raw_b", {15'h0, raw_valid_ff, raw_b_ff}, 32'h1_0003);
            end
            @(posedge clk_sys);
        end
        smp_valid <= 1'b0;
        repeat (4) @(posedge clk_sys);
    endtask : cap
    task automatic wrap_up();
        if (err_total == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    // ============
    // tests
    initial begin
        {reg_wr, reg_rd, aux_i, aux2_i, ext_trig_i, trig_i, smp_valid} = '0;
        {m0, reg_addr, reg_wdata, smp_a, smp_b, raw_exp} = '0;
        {err_total, num_checks, n_acc, n_te} = '0;
        rst = 1'b1;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        rd(AXA_REG_AUX_PARAM, '1, 32'h4);
        rd(8'h24, '1, 32'h0);
        rd(AXA_REG_CMD, '1, 32'h0);
        wr(AXA_REG_AVG_CNT, '1);
        rd(AXA_REG_AVG_CNT, '1, 32'hFF_FFFF);
        pin(2'b10);
        wr(AXA_REG_REC_LEN, 32'h2);
        wr(AXA_REG_LOWBIT, 32'h21);
        {ext_trig_i, aux2_i, m0} <= 3'b111;
        raw_exp <= 16'h1233;
        cap(16'h1230, 16'h0);
        rd(AXA_REG_STATUS, 32'h1, 32'h0);
        m0 <= 1'b0;
        wr(AXA_REG_BUF_RECS, 32'h1);
        wr(AXA_REG_AUX_MODE, 32'h10);
        cap(16'h0, 16'h0);
        wr(AXA_REG_CMD, 32'h1);
        cap(16'h0, 16'h0);
        cap(16'h0, 16'h0);
        chk("accepts", n_acc, 2);
        for (int v = 0; v < 2; v++) begin
            wr(AXA_REG_AUX_PARAM, 32'(v));
            wr(AXA_REG_AUX_MODE, 32'hE);
            pin({1'b1, 1'(v)});
        end
        wr(AXA_REG_AUX_MODE, 32'hD);
        for (int v = 0; v < 2; v++) begin
            aux_i <= 1'(v);
            repeat (3) @(posedge clk_sys);
            rd(AXA_REG_STATUS, 32'h2, 32'(2 * v));
        end
        wr(AXA_REG_AUX_PARAM, 32'h6);
        wr(AXA_REG_AUX_MODE, 32'h2);
        hi = 0;
        repeat (12) begin
            @(negedge clk_sys);
            hi += int'(aux_o_ff);
        end
        chk("pacer", hi, 6);
        @(posedge clk_sys);
        aux_i <= 1'b0;
        wr(AXA_REG_AUX_MODE, 32'h1);
        for (int s = 0; s < 4; s++) begin
            if (s == 2) wr(AXA_REG_AUX_PARAM, 32'h1);
            aux_i <= ~aux_i;
            repeat (4) @(posedge clk_sys);
            if (s == 0) chk("te_rise", n_te, 2);
        end
        chk("te_fall", n_te, 3);
        wr(AXA_REG_AUX_MODE, 32'h0);
        wr(AXA_REG_LOWBIT, 32'h0);
        wr(AXA_REG_AVG_CNT, 32'h2);
        wr(AXA_REG_AVG_CTRL, 32'h3);
        cap(16'h1000, 16'hFFF0);
        cap(16'h1000, 16'hFFF0);
        repeat (40) @(posedge clk_sys);
        chk("bytes", nbytes, 16);
        chk("last", last_n, 16);
        for (int i = 0; i < 2; i++) begin
            chk("sum_a", words[2*i], 32'h2000 + 32'(8 * i));
            chk("sum_b", words[2*i+1], 32'hFFFF_FFE0 - 32'(8 * i));
        end
        wrap_up();
    end
endmodule : tb_top
